// ==== smp_spi_port.sv ====
// serial master/slave port with apb register access and four shared pins
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module smp_spi_port
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // pins: bit0 miso, bit1 mosi, bit2 sck, bit3 select
    input  wire logic [3:0]  pin_i,
    output logic      [3:0]  pin_o,
    output logic      [3:0]  pin_oe,
    output logic      [3:0]  pin_pullup,
    output logic             reduced_drive,
    // interrupt request
    output logic             irq
);
    logic [7:0]  ctrl1_r;
    logic [7:0]  ctrl2_r;
    logic [7:0]  baud_r;
    logic [7:0]  dir_r;
    logic [7:0]  port_r;
    logic        done_f_r;
    logic        write_collision_flag_r;
    logic        mode_fault_flag_r;
    logic [2:0]  arm_r;
    logic [7:0]  sh_r;
    logic [7:0]  rx_r;
    logic        lat_r;
    logic [3:0]  k_r;
    logic [7:0]  cnt_r;
    logic        sck_lvl_r;
    logic        sck_p_r;
    logic [3:0]  s1_r;
    logic [3:0]  s2_r;
    logic [3:0]  s3_r;
    logic [3:0]  filt_r;
    logic [31:0] prdata_r;
    logic [3:0]  pin_o_r;
    logic [3:0]  pin_oe_r;
    smp_pkg::smp_state_e st_r;

    logic        en;
    logic        master;
    logic        clock_polarity_bit;
    logic        clock_phase_bit;
    logic        bit_order_control;
    logic        bidir;
    logic        ss_f;
    logic        master_run;
    logic        busy;
    logic [7:0]  half_m1;
    logic        div_hit;
    logic        slave_edge;
    logic        edge_ev;
    logic        sample_e;
    logic        done;
    logic        rx_in;
    logic        tx_bit;
    logic [7:0]  sh_last;
    logic        acc;
    logic        wr;
    logic        rd;
    logic        wr_data;
    logic        acc_data;
    logic        start;
    logic        mode_fault_flag_set;
    logic        unmapped;
    logic [7:0]  rd_mux;
    logic [3:0]  drv;
    logic [3:0]  val;

    function automatic logic [7:0] shf(input logic [7:0] s, input logic b, input logic l);
        shf = l ? {b, s[7:1]} : {s[6:0], b};
    endfunction : shf

    // mode fault drops the enable at once, so the pins fall back and the engines stop
    assign en     = ctrl1_r[smp_pkg::C1_SYS_EN] & ~mode_fault_flag_r;
    assign master = ctrl1_r[smp_pkg::C1_MASTER];
    assign clock_polarity_bit   = ctrl1_r[smp_pkg::C1_CLOCK_POLARITY_BIT];
    assign clock_phase_bit   = ctrl1_r[smp_pkg::C1_CLOCK_PHASE_BIT];
    assign bit_order_control   = ctrl1_r[smp_pkg::C1_BIT_ORDER_CONTROL];
    assign bidir  = ctrl2_r[smp_pkg::C2_PINMODE];
    assign ss_f   = filt_r[smp_pkg::P_SS];

    // apb decode
    assign acc      = psel & penable;
    assign wr       = acc & pwrite;
    assign rd       = acc & ~pwrite;
    assign wr_data  = wr & (paddr == smp_pkg::OFF_DATA);
    assign acc_data = acc & (paddr == smp_pkg::OFF_DATA);
    assign unmapped = (paddr != smp_pkg::OFF_CTRL1) && (paddr != smp_pkg::OFF_CTRL2)
                   && (paddr != smp_pkg::OFF_BAUD) && (paddr != smp_pkg::OFF_STAT)
                   && (paddr != smp_pkg::OFF_DATA) && (paddr != smp_pkg::OFF_DIR)
                   && (paddr != smp_pkg::OFF_PORT);
    assign pready  = 1'b1;
    assign pslverr = acc & unmapped;
    assign prdata  = prdata_r;

    assign master_run = (st_r == smp_pkg::SMP_XFER);
    assign busy       = master_run | (k_r != 4'h0);
    assign start      = wr_data & en & master & ~busy;

    // half period in clocks is 2^rate, giving divisors 2..256
    assign half_m1 = (8'h01 << baud_r[2:0]) - 8'h01;
    assign div_hit = master_run && (cnt_r == half_m1);

    // slave follows the external clock only while selected
    assign slave_edge = en & ~master & ~ss_f & (filt_r[smp_pkg::P_SCK] != sck_p_r);
    assign edge_ev    = master_run ? div_hit : slave_edge;
    // even edges lead; phase bit moves sampling to the trailing edge
    assign sample_e   = ~k_r[0] ^ clock_phase_bit;
    assign done       = edge_ev && (k_r == smp_pkg::LAST_EDGE);

    // received bits pass the pin synchroniser: a master read needs a half period of 8 clocks or more
    assign rx_in  = master ? (bidir ? filt_r[smp_pkg::P_MOSI] : filt_r[smp_pkg::P_MISO])
                           : (bidir ? filt_r[smp_pkg::P_MISO] : filt_r[smp_pkg::P_MOSI]);
    assign tx_bit = bit_order_control ? sh_r[0] : sh_r[7];
    assign sh_last = clock_phase_bit ? shf(sh_r, rx_in, bit_order_control) : shf(sh_r, lat_r, bit_order_control);

    assign mode_fault_flag_set = ctrl1_r[smp_pkg::C1_SYS_EN] & master & ~dir_r[7]
                    & ~ss_f;

    // read mux; the enable reads back as 0 while a mode fault stands
    always_comb
    begin
        rd_mux = 8'h00;
        unique case (paddr)
            smp_pkg::OFF_CTRL1:
            begin
                rd_mux = ctrl1_r;
                rd_mux[smp_pkg::C1_SYS_EN] = en;
            end
            smp_pkg::OFF_CTRL2: rd_mux = ctrl2_r;
            smp_pkg::OFF_BAUD:  rd_mux = baud_r;
            smp_pkg::OFF_STAT:
            begin
                rd_mux[smp_pkg::ST_DONE] = done_f_r;
                rd_mux[smp_pkg::ST_WRITE_COLLISION_FLAG] = write_collision_flag_r;
                rd_mux[smp_pkg::ST_MODE_FAULT_FLAG] = mode_fault_flag_r;
            end
            smp_pkg::OFF_DATA:  rd_mux = rx_r;
            smp_pkg::OFF_DIR:   rd_mux = dir_r;
            smp_pkg::OFF_PORT:  rd_mux = port_r;
            default:            rd_mux = 8'h00;
        endcase
    end

    // read data is captured in the setup cycle and held through the access
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            prdata_r <= 32'h00000000;
        else if (psel && !penable)
            prdata_r <= {24'h000000, rd_mux};
    end

    // control registers
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl1_r <= smp_pkg::CTRL1_RST;
            ctrl2_r <= smp_pkg::CTRL2_RST;
            baud_r  <= smp_pkg::BAUD_RST;
            dir_r   <= smp_pkg::DIR_RST;
            port_r  <= smp_pkg::PORT_RST;
        end
        else if (wr)
        begin
            if (paddr == smp_pkg::OFF_CTRL1)
                ctrl1_r <= pwdata[7:0];
            if (paddr == smp_pkg::OFF_CTRL2)
                ctrl2_r <= pwdata[7:0] & smp_pkg::C2_MASK;
            if (paddr == smp_pkg::OFF_BAUD)
                baud_r <= pwdata[7:0] & smp_pkg::BAUD_MASK;
            if (paddr == smp_pkg::OFF_DIR)
                dir_r <= pwdata[7:0];
            if (paddr == smp_pkg::OFF_PORT)
                port_r <= pwdata[7:0];
        end
    end

    // status read arms the flags it saw; the following access clears only those
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            arm_r <= 3'h0;
        else if (rd && paddr == smp_pkg::OFF_STAT)
            arm_r <= {prdata_r[smp_pkg::ST_DONE], prdata_r[smp_pkg::ST_WRITE_COLLISION_FLAG], prdata_r[smp_pkg::ST_MODE_FAULT_FLAG]};
        else if (acc_data)
            arm_r <= {1'b0, 1'b0, arm_r[0]};
        else if (wr && paddr == smp_pkg::OFF_CTRL1)
            arm_r <= {arm_r[2:1], 1'b0};
    end

    // flags: a setting event in the clearing cycle wins
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            done_f_r <= 1'b0;
            write_collision_flag_r   <= 1'b0;
            mode_fault_flag_r   <= 1'b0;
        end
        else
        begin
            if (done)
                done_f_r <= 1'b1;
            else if (acc_data && arm_r[2])
                done_f_r <= 1'b0;
            if (wr_data && busy)
                write_collision_flag_r <= 1'b1;
            else if (acc_data && arm_r[1])
                write_collision_flag_r <= 1'b0;
            if (mode_fault_flag_set)
                mode_fault_flag_r <= 1'b1;
            else if (wr && paddr == smp_pkg::OFF_CTRL1 && arm_r[0])
                mode_fault_flag_r <= 1'b0;
        end
    end

    // write collision raises no request; only done and mode fault do
    assign irq = ctrl1_r[smp_pkg::C1_IRQ_EN] & (done_f_r | mode_fault_flag_r);

    // pin synchronisers; a change is taken once stages two and three agree
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s1_r    <= 4'hf;
            s2_r    <= 4'hf;
            s3_r    <= 4'hf;
            filt_r  <= 4'hf;
            sck_p_r <= 1'b1;
        end
        else
        begin
            s1_r    <= pin_i;
            s2_r    <= s1_r;
            s3_r    <= s2_r;
            filt_r  <= (s2_r & s3_r) | (filt_r & (s2_r ^ s3_r));
            sck_p_r <= filt_r[smp_pkg::P_SCK];
        end
    end

    // master sequencer
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            st_r <= smp_pkg::SMP_IDLE;
        else if (!en)
            st_r <= smp_pkg::SMP_IDLE;
        else
        begin
            unique case (st_r)
                smp_pkg::SMP_IDLE: if (start) st_r <= smp_pkg::SMP_XFER;
                smp_pkg::SMP_XFER: if (done) st_r <= smp_pkg::SMP_IDLE;
            endcase
        end
    end

    // baud divider, held at zero outside a master transfer to save power
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            cnt_r <= 8'h00;
        else if (!master_run || div_hit)
            cnt_r <= 8'h00;
        else
            cnt_r <= cnt_r + 8'h01;
    end

    // master clock phase; sixteen toggles bring it back to idle level
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            sck_lvl_r <= 1'b0;
        else if (!master_run)
            sck_lvl_r <= 1'b0;
        else if (div_hit)
            sck_lvl_r <= ~sck_lvl_r;
    end

    // edge counter, shared by both roles; deselect aborts a slave transfer
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            k_r <= 4'h0;
        else if (!en || (!master_run && (master || ss_f)))
            k_r <= 4'h0;
        else if (edge_ev)
            k_r <= k_r + 4'h1;
    end

    // shifter: sample on one edge, shift on the other, eight bits per transfer
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sh_r  <= 8'h00;
            lat_r <= 1'b0;
            rx_r  <= 8'h00;
        end
        else if ((start || (wr_data && !master)) && !busy)
            sh_r <= pwdata[7:0];
        else if (done)
        begin
            // a master keeps its last data bit standing through the closing clock edge
            if (!master)
                sh_r <= sh_last;
            rx_r <= sh_last;
        end
        else if (edge_ev)
        begin
            if (sample_e)
                lat_r <= rx_in;
            else if (!(clock_phase_bit && k_r == 4'h0))
                sh_r <= shf(sh_r, lat_r, bit_order_control);
        end
    end

    // pin roles
    always_comb
    begin
        drv = dir_r[7:4] & {4{~en}};
        val = port_r[7:4];
        if (en && master)
        begin
            drv[smp_pkg::P_MISO] = bidir & dir_r[4];
            drv[smp_pkg::P_MOSI] = dir_r[5];
            val[smp_pkg::P_MOSI] = tx_bit;
            drv[smp_pkg::P_SCK]  = dir_r[6];
            val[smp_pkg::P_SCK]  = clock_polarity_bit ^ sck_lvl_r;
            drv[smp_pkg::P_SS]   = dir_r[7];
            if (ctrl1_r[smp_pkg::C1_SELECT_OUTPUT_ENABLE])
                val[smp_pkg::P_SS] = ~master_run;
        end
        else if (en)
        begin
            drv[smp_pkg::P_MISO] = dir_r[4] & ~ss_f;
            val[smp_pkg::P_MISO] = tx_bit;
            drv[smp_pkg::P_MOSI] = bidir & dir_r[5];
            drv[smp_pkg::P_SCK]  = 1'b0;
            drv[smp_pkg::P_SS]   = 1'b0;
        end
    end

    // registered pin drivers; open-drain only ever pulls low
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pin_o_r  <= 4'h0;
            pin_oe_r <= 4'h0;
        end
        else
        begin
            pin_o_r  <= val;
            pin_oe_r <= drv & (~val | {4{~ctrl1_r[smp_pkg::C1_WOR]}});
        end
    end

    assign pin_o         = pin_o_r;
    assign pin_oe        = pin_oe_r;
    // pull-ups follow the driver decision, so an output pin never has one
    assign pin_pullup    = {4{ctrl2_r[smp_pkg::C2_PULLUP]}} & ~drv;
    assign reduced_drive = ctrl2_r[smp_pkg::C2_RDS];

endmodule : smp_spi_port

// ==== smp_pkg.sv ====
// constants for the serial master/slave port block
// Functional notes
// - while enabled, pins the configuration treats as inputs are inputs regardless of direction bits
// - serial outputs drive only with direction bit set; otherwise usable as plain inputs
// - serial clock is peripheral clock divided by 2..256, chosen by 3-bit rate field
// - baud divider runs only in master mode during a transfer
// - each transfer shifts the linked 8-bit registers eight places, exchanging words
// - polarity bit clear keeps idle clock low; set keeps it high
// - phase bit picks half-cycle shifted or unshifted sampling; four formats in all
// - enabled select output goes low for each transfer, high when idle
// - master select pin role follows direction bit and select output enable
// - bidirectional mode uses one data pin, direction from its direction bit
// - irq enable requests interrupt while transfer-done or mode-fault flag is set
// - clearing system enable reinitialises the logic; setting it claims the four pins
// - system enable reads 0 during mode fault; control one write clears it (the code clears it only after a status read returned the flag)
// - wired-or bit makes serial and general outputs open-drain
// - bit order 0 sends MSB first, 1 LSB first; register keeps MSB in bit 7
// - pin mode and master bit assign roles to the four pins
// - pull-up bit enables pull-ups on input pins, never on outputs
// - reduced-drive bit selects reduced output drive strength
// - transfer-done set after eighth clock; cleared by status read then data access
// - mode fault set when master and select input low, unless select direction set
// - data write during a transfer is blocked and sets write collision, no interrupt
// - after reset the rate field selects division by 2
package smp_pkg;
    localparam logic [7:0] OFF_CTRL1 = 8'h00;
    localparam logic [7:0] OFF_CTRL2 = 8'h04;
    localparam logic [7:0] OFF_BAUD  = 8'h08;
    localparam logic [7:0] OFF_STAT  = 8'h0c;
    localparam logic [7:0] OFF_DATA  = 8'h10;
    localparam logic [7:0] OFF_DIR   = 8'h14;
    localparam logic [7:0] OFF_PORT  = 8'h18;
    // serial_control_one fields
    localparam int C1_IRQ_EN = 7;
    localparam int C1_SYS_EN = 6;
    localparam int C1_WOR    = 5;
    localparam int C1_MASTER = 4;
    localparam int C1_CLOCK_POLARITY_BIT   = 3;
    localparam int C1_CLOCK_PHASE_BIT   = 2;
    localparam int C1_SELECT_OUTPUT_ENABLE   = 1;
    localparam int C1_BIT_ORDER_CONTROL   = 0;
    // serial_control_two fields
    localparam int C2_PULLUP = 3;
    localparam int C2_RDS    = 2;
    localparam int C2_PINMODE = 0;
    localparam logic [7:0] C2_MASK = 8'h0d;
    // serial_status_register fields
    localparam int ST_DONE = 7;
    localparam int ST_WRITE_COLLISION_FLAG = 6;
    localparam int ST_MODE_FAULT_FLAG = 4;
    localparam logic [7:0] BAUD_MASK = 8'h07;
    // pin indices inside the four-pin group (port bits 4..7)
    localparam int P_MISO = 0;
    localparam int P_MOSI = 1;
    localparam int P_SCK  = 2;
    localparam int P_SS   = 3;
    localparam logic [7:0] CTRL1_RST = 8'h04;
    localparam logic [7:0] CTRL2_RST = 8'h00;
    localparam logic [7:0] BAUD_RST  = 8'h00;
    localparam logic [7:0] DIR_RST   = 8'h00;
    localparam logic [7:0] PORT_RST  = 8'h00;
    localparam logic [3:0] LAST_EDGE = 4'hf;
    typedef enum logic {SMP_IDLE, SMP_XFER} smp_state_e;
endpackage : smp_pkg

// ==== smp_spi_port_properties.sv ====
// assertions on the serial port's bus answers and pin behaviour
`timescale 1ns/1ps
module smp_spi_port_props
(
    // clock and reset
    input wire logic        clk,
    input wire logic        nrst,
    // bus
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // pins
    input wire logic [3:0]  pin_o,
    input wire logic [3:0]  pin_oe,
    input wire logic        reduced_drive,
    input wire logic        irq
);
    logic [4:0] sck_cnt_r;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // clock toggles seen while select was low; cleared when select is not ours
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            sck_cnt_r <= 5'h00;
        else if (!pin_oe[3] || $fell(pin_o[3]))
            sck_cnt_r <= 5'h00;
        else if (!$past(pin_o[3]) && $changed(pin_o[2]))
            sck_cnt_r <= sck_cnt_r + 5'h01;
    end
    // a control write may raise a select that was a plain output, so skip that case
    property p_edges;
        $rose(pin_o[3]) && pin_oe[3] && $past(pin_oe[3]) && !$past(psel && pwrite, 2) |=> sck_cnt_r == 5'h10;
    endproperty
    a_edges: assert property (p_edges) else $error("clock edge count per frame wrong");
    // a register write may move the idle level, so skip two cycles after one
    property p_sck_quiet;
        pin_oe[3] && pin_o[3] && $past(pin_o[3]) && !$past(psel && pwrite)
            && !$past(psel && pwrite, 2) |-> $stable(pin_o[2]);
    endproperty
    a_sck_quiet: assert property (p_sck_quiet) else $error("clock moved while idle");
    property p_upper;
        psel && penable && !pwrite |-> prdata[31:8] == 24'h000000;
    endproperty
    a_upper: assert property (p_upper) else $error("upper read bits not zero");
    property p_unmapped;
        psel && penable && (paddr > 8'h18 || paddr[1:0] != 2'h0) |-> pslverr && (pwrite || prdata == 32'h0);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    property p_mapped;
        psel && penable && paddr <= 8'h18 && paddr[1:0] == 2'h0 |-> !pslverr;
    endproperty
    a_mapped: assert property (p_mapped) else $error("mapped access refused");
    property p_ready;
        psel && !penable |=> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("access phase not answered");
    property p_stands;
        !psel && $past(!psel) |-> $stable(prdata);
    endproperty
    a_stands: assert property (p_stands) else $error("read data moved while bus idle");
    property p_reset_out;
        $rose(nrst) |-> pin_oe == 4'h0 && !irq && !reduced_drive;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("outputs active after reset");
endmodule : smp_spi_port_props

// ==== smp_spi_partner.sv ====
// far-side serial device: exchanges one byte per select frame
`timescale 1ns/1ps
module smp_spi_partner
(
    // link pins
    input wire logic       sck,
    input wire logic       sel_n,
    input wire logic       mosi,
    output logic           miso,
    // format and data
    input wire logic       clock_polarity_bit,
    input wire logic       clock_phase_bit,
    input wire logic       bit_order_control,
    input wire logic [7:0] load,
    output logic     [7:0] rx
);
    logic [7:0] tx = 8'h00;
    logic       bit_o = 1'b0;
    logic       last = 1'b0;
    int         n = 16;
    wire        lead = sck ^ clock_polarity_bit;
    initial rx = 8'h00;
    task present;
        bit_o = bit_order_control ? tx[0] : tx[7];
        tx = bit_order_control ? tx >> 1 : tx << 1;
    endtask : present
    task sample;
        rx = bit_order_control ? {mosi, rx[7:1]} : {rx[6:0], mosi};
    endtask : sample
    always @(negedge sel_n)
    begin
        n = 0;
        tx = load;
        if (!clock_phase_bit)
            present();
    end
    // the closing edge may meet the select rise in one step, so edges are counted per frame
    always @(posedge lead)
    begin
        if (n < 16 && (!sel_n || n == 15))
        begin
            n++;
            if (clock_phase_bit)
                present();
            else
                sample();
        end
    end
    always @(negedge lead)
    begin
        if (n < 16 && (!sel_n || n == 15))
        begin
            n++;
            if (clock_phase_bit)
                sample();
            else
                present();
        end
    end
    // a released line shows the inverse of its last bit, never a stale copy
    always @(posedge sel_n)
        last = bit_o;
    assign miso = sel_n ? ~last : bit_o;
endmodule : smp_spi_partner

// ==== smp_spi_port_bench.sv ====
// bench for the serial port: transfers, flags, registers and reset
`timescale 1ns/1ps
module smp_spi_port_bench;
    typedef struct {logic [2:0] fmt; logic [2:0] rate; logic [7:0] mtx; logic [7:0] stx;} smp_row_s;
    logic        clk, nrst, psel, penable, pwrite, ss_drv, pready, pslverr, reduced_drive, irq, miso, er;
    logic [7:0]  paddr, load, rx;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pin_i, pin_o, pin_oe, pin_pullup;
    logic [2:0]  fmt;
    int          n_mismatch, checked, cyc;
    // replies cross the pin synchroniser, so read rates keep half periods of 8 clocks or more
    smp_row_s    rows [6] = '{'{3'h0, 3'h3, 8'h3c, 8'ha5}, '{3'h4, 3'h4, 8'hc3, 8'h5a},
                              '{3'h2, 3'h3, 8'h81, 8'h7e}, '{3'h6, 3'h5, 8'h0f, 8'hf0},
                              '{3'h1, 3'h3, 8'h01, 8'h80}, '{3'h7, 3'h7, 8'h96, 8'h69}};
    // undriven pins: select follows ss_drv, mosi held high, sck at the chosen idle level
    assign pin_i = {pin_oe[3] ? pin_o[3] : ss_drv, pin_oe[2] ? pin_o[2] : fmt[2],
                    pin_oe[1] ? pin_o[1] : 1'b1, miso};
    smp_spi_port uut (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
                      .pslverr, .pin_i, .pin_o, .pin_oe, .pin_pullup, .reduced_drive, .irq);
    smp_spi_partner far (.sck(pin_i[2]), .sel_n(pin_i[3]), .mosi(pin_i[1]), .miso, .clock_polarity_bit(fmt[2]),
                         .clock_phase_bit(fmt[1]), .bit_order_control(fmt[0]), .load, .rx);
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task finish_test;
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            finish_test();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task rdchk(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(rd, {24'h0, e});
    endtask : rdchk
    // polls status; each read also arms the flags that it returns
    task wait_st(input logic [7:0] m);
        for (int i = 0; i < 1000; i++)
        begin
            apb(1'b0, smp_pkg::OFF_STAT, 8'h00);
            if ((rd[7:0] & m) != 8'h00)
                break;
        end
    endtask : wait_st
    initial
    begin
        {nrst, psel, penable, pwrite, paddr, pwdata, fmt, load} = '0;
        {ss_drv, n_mismatch, checked, cyc} = '0;
        ss_drv = 1'b1;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        apb(1'b1, smp_pkg::OFF_DIR, 8'he0);
        foreach (rows[i])
        begin
            fmt <= rows[i].fmt;
            load <= rows[i].stx;
            apb(1'b1, smp_pkg::OFF_BAUD, {5'h0, rows[i].rate});
            apb(1'b1, smp_pkg::OFF_CTRL1, {4'h5, rows[i].fmt[2:1], 1'b1, rows[i].fmt[0]});
            apb(1'b1, smp_pkg::OFF_DATA, rows[i].mtx);
            wait_st(8'h80);
            chk(rd, 32'h80);
            chk({24'h0, rx}, {24'h0, rows[i].mtx});
            rdchk(smp_pkg::OFF_DATA, rows[i].stx);
            rdchk(smp_pkg::OFF_STAT, 8'h00);
            chk({30'h0, pin_o[3:2]}, {30'h0, 1'b1, rows[i].fmt[2]});
        end
        load <= 8'h44;
        apb(1'b1, smp_pkg::OFF_DATA, 8'h11);
        apb(1'b1, smp_pkg::OFF_DATA, 8'h22);
        wait_st(8'h80);
        chk(rd, 32'hc0);
        chk({24'h0, rx}, 32'h11);
        rdchk(smp_pkg::OFF_DATA, 8'h44);
        rdchk(smp_pkg::OFF_STAT, 8'h00);
        apb(1'b1, smp_pkg::OFF_DIR, 8'h60);
        apb(1'b1, smp_pkg::OFF_CTRL1, 8'hd0);
        ss_drv <= 1'b0;
        wait_st(8'h10);
        chk(rd, 32'h10);
        chk({31'h0, irq}, 32'h1);
        rdchk(smp_pkg::OFF_CTRL1, 8'h90);
        ss_drv <= 1'b1;
        // three-stage input synchroniser must see select high before recovery
        repeat (4) @(posedge clk);
        apb(1'b1, smp_pkg::OFF_CTRL1, 8'h50);
        rdchk(smp_pkg::OFF_STAT, 8'h00);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, smp_pkg::OFF_CTRL2, 8'hff);
        rdchk(smp_pkg::OFF_CTRL2, 8'h0d);
        chk({31'h0, reduced_drive}, 32'h1);
        chk({28'h0, pin_pullup}, 32'h9);
        apb(1'b1, smp_pkg::OFF_BAUD, 8'hff);
        rdchk(smp_pkg::OFF_BAUD, 8'h07);
        apb(1'b1, smp_pkg::OFF_STAT, 8'hff);
        rdchk(smp_pkg::OFF_STAT, 8'h00);
        rdchk(8'h1c, 8'h00);
        chk({31'h0, er}, 32'h1);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rdchk(smp_pkg::OFF_CTRL1, 8'h04);
        rdchk(smp_pkg::OFF_CTRL2, 8'h00);
        rdchk(smp_pkg::OFF_BAUD, 8'h00);
        rdchk(smp_pkg::OFF_DIR, 8'h00);
        chk({28'h0, pin_oe}, 32'h0);
        finish_test();
    end
endmodule : smp_spi_port_bench
bind smp_spi_port smp_spi_port_props props_i (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .prdata,
                                              .pready, .pslverr, .pin_o, .pin_oe, .reduced_drive, .irq);
